// ---- design/sdap_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sdap_defs.svh"

module sdap_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,   // System clock
    input  wire logic             rst_n,     // Async reset
    input  wire logic             in_valid,  // Write request
    output logic                  in_ready,  // Not full
    input  wire logic [WIDTH-1:0] in_data,   // Write data
    output logic                  out_valid, // Not empty
    input  wire logic             out_ready, // Drain request
    output logic      [WIDTH-1:0] out_data   // Head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    wr_next;
    logic [AW-1:0]    rd_reg;
    logic [AW-1:0]    rd_next;
    logic [AW:0]      cnt_reg;
    logic [AW:0]      cnt_next;
    logic             push;
    logic             pop;

    always_comb
    begin
        in_ready  = (cnt_reg != (AW+1)'(DEPTH));
        out_valid = (cnt_reg != '0);
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_next   = push ? wr_reg + 1'b1 : wr_reg;
        rd_next   = pop ? rd_reg + 1'b1 : rd_reg;
        cnt_next  = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        out_data  = mem[rd_reg];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wr_reg] <= in_data;
    end
endmodule

module sdap_core (
    input  wire logic                    clk_sys,      // System clock, 125 MHz
    input  wire logic                    rst_n,        // Async reset, active low
    input  wire logic                    clk_gate,     // Internal clock enable
    input  wire sdap_pkg::sdap_cmd_bus_t cmd_in,       // Command, bank, address
    input  wire logic                    byte_mask,    // Data mask
    input  wire logic [15:0]             data_lines_i, // Data pins in
    output logic      [15:0]             data_lines_o, // Data pins out
    output logic                         data_lines_oe,// High while driving
    output logic      [11:0]             mode_word,    // Stored mode register
    output logic      [3:0]              bank_open,    // Row open per bank
    output logic                         wr_valid,     // Write word to store
    input  wire logic                    wr_ready,     // Store accepts word
    output sdap_pkg::sdap_word_t         wr_word       // Bank/row/col/data
);
    sdap_pkg::sdap_cmd_t   cmd;
    sdap_pkg::sdap_state_t st_reg, st_next;
    logic [11:0] mode_reg, mode_next;
    logic [3:0]  open_reg, open_next;
    logic [11:0] row_reg [4];
    logic [11:0] row_next [4];
    logic [1:0]  bk_reg, bk_next;
    logic [7:0]  col_reg, col_next;
    logic [7:0]  base_reg, base_next;
    logic [8:0]  left_reg, left_next;
    logic        ap_reg, ap_next;
    logic [15:0] dout_reg, dout_next;
    logic        oe_reg, oe_next;
    logic [15:0] mem [`SDAP_MEM_DEPTH];
    logic [8:0]  blen;
    logic [7:0]  step_col;
    logic        fifo_in_ready;
    logic        stall;
    sdap_pkg::sdap_word_t fifo_in;

    // Truth table decode of select and strobes
    always_comb
    begin
        if (cmd_in.chip_sel_n)
            cmd = sdap_pkg::SDAP_CMD_INHIBIT;
        else
            case ({cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n})
                3'h7:    cmd = sdap_pkg::SDAP_CMD_NOP;
                3'h3:    cmd = sdap_pkg::SDAP_CMD_ACTIVE;
                3'h5:    cmd = sdap_pkg::SDAP_CMD_READ;
                3'h4:    cmd = sdap_pkg::SDAP_CMD_WRITE;
                3'h2:    cmd = sdap_pkg::SDAP_CMD_PRECH;
                3'h1:    cmd = sdap_pkg::SDAP_CMD_REFRESH;
                3'h0:    cmd = sdap_pkg::SDAP_CMD_MODE;
                3'h6:    cmd = sdap_pkg::SDAP_CMD_TERM;
                default: cmd = sdap_pkg::SDAP_CMD_NOP;
            endcase
    end

    // Burst length from mode bits; full page is the whole 256-column row
    always_comb
    begin
        case (mode_reg[`SDAP_BL_LSB +: 3])
            3'h0:    blen = 9'h001;
            3'h1:    blen = 9'h002;
            3'h2:    blen = 9'h004;
            3'h3:    blen = 9'h008;
            3'h7:    blen = 9'h100;
            default: blen = 9'h001;
        endcase
    end

    // Next column wraps inside the block; interleave flips low bits
    always_comb
    begin
        step_col = col_reg;
        if (mode_reg[`SDAP_BT_BIT] && blen != 9'h100)
            step_col = base_reg ^ 8'(blen - left_reg + 9'h001);
        else
            step_col = (col_reg & ~8'(blen - 9'h001))
                     | ((col_reg + 8'h01) & 8'(blen - 9'h001));
        if (blen == 9'h100)
            step_col = col_reg + 8'h01;
    end

    assign stall = (st_reg == sdap_pkg::SDAP_ST_WRITE) && !fifo_in_ready;

    always_comb
    begin
        st_next   = st_reg;
        mode_next = mode_reg;
        open_next = open_reg;
        row_next  = row_reg;
        bk_next   = bk_reg;
        col_next  = col_reg;
        base_next = base_reg;
        left_next = left_reg;
        ap_next   = ap_reg;
        dout_next = dout_reg;
        oe_next   = oe_reg;
        fifo_in   = '{bank: bk_reg, row: row_reg[bk_reg], col: col_reg, data: data_lines_i};
        // Clock gate low freezes every register of this block, output enable too; the FIFO read side still drains
        if (clk_gate)
        begin
            oe_next = 1'b0;
            // Bursts run on under chip select high; a full FIFO holds only the beat,
            // commands are still decoded so none is lost to a slow sink
            if (st_reg != sdap_pkg::SDAP_ST_IDLE && !stall)
            begin
                if (st_reg == sdap_pkg::SDAP_ST_READ)
                begin
                    dout_next = mem[{bk_reg, col_reg[3:0]}];
                    oe_next   = !byte_mask;
                end
                col_next  = step_col;
                left_next = left_reg - 9'h001;
                if (left_reg == 9'h001)
                begin
                    st_next = sdap_pkg::SDAP_ST_IDLE;
                    if (ap_reg)
                        open_next[bk_reg] = 1'b0;
                end
            end
            case (cmd)
                sdap_pkg::SDAP_CMD_ACTIVE:
                begin
                    // Bank and row captured together
                    open_next[cmd_in.bank_select_lines] = 1'b1;
                    row_next[cmd_in.bank_select_lines]  = cmd_in.multiplexed_address_lines;
                end
                sdap_pkg::SDAP_CMD_READ, sdap_pkg::SDAP_CMD_WRITE:
                begin
                    // Starting column and auto precharge flag
                    st_next   = (cmd == sdap_pkg::SDAP_CMD_READ) ? sdap_pkg::SDAP_ST_READ
                                                                 : sdap_pkg::SDAP_ST_WRITE;
                    bk_next   = cmd_in.bank_select_lines;
                    col_next  = cmd_in.multiplexed_address_lines[`SDAP_COL_W-1:0];
                    base_next = cmd_in.multiplexed_address_lines[`SDAP_COL_W-1:0];
                    left_next = blen;
                    ap_next   = cmd_in.multiplexed_address_lines[`SDAP_SCOPE_BIT];
                end
                sdap_pkg::SDAP_CMD_PRECH:
                begin
                    if (cmd_in.multiplexed_address_lines[`SDAP_SCOPE_BIT])
                        open_next = 4'h0;
                    else
                        open_next[cmd_in.bank_select_lines] = 1'b0;
                end
                sdap_pkg::SDAP_CMD_TERM:
                    st_next = sdap_pkg::SDAP_ST_IDLE;
                sdap_pkg::SDAP_CMD_MODE:
                begin
                    // Opcode latched; held until next load, outputs released
                    mode_next = cmd_in.multiplexed_address_lines;
                    st_next   = sdap_pkg::SDAP_ST_IDLE;
                    oe_next   = 1'b0;
                end
                default:
                begin
                end
            endcase
        end
    end

    // All inputs but the async reset captured only on the rising edge
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg   <= sdap_pkg::SDAP_ST_IDLE;
            mode_reg <= `SDAP_MODE_RST;
            open_reg <= 4'h0;
            for (int i = 0; i < `SDAP_BANKS; i++)
                row_reg[i] <= 12'h000;
            bk_reg   <= 2'h0;
            col_reg  <= 8'h00;
            base_reg <= 8'h00;
            left_reg <= 9'h000;
            ap_reg   <= 1'b0;
            dout_reg <= 16'h0000;
            oe_reg   <= 1'b0;
        end
        else
        begin
            st_reg   <= st_next;
            mode_reg <= mode_next;
            open_reg <= open_next;
            row_reg  <= row_next;
            bk_reg   <= bk_next;
            col_reg  <= col_next;
            base_reg <= base_next;
            left_reg <= left_next;
            ap_reg   <= ap_next;
            dout_reg <= dout_next;
            oe_reg   <= oe_next;
        end
    end

    // Small local store so reads return written data; masked bytes not stored
    always_ff @(posedge clk_sys)
    begin
        if (clk_gate && !stall && st_reg == sdap_pkg::SDAP_ST_WRITE && !byte_mask)
            mem[{bk_reg, col_reg[3:0]}] <= data_lines_i;
    end

    // Write words leave through the FIFO; a full FIFO stalls the burst
    sdap_fifo #(
        .WIDTH ($bits(sdap_pkg::sdap_word_t)),
        .DEPTH (`SDAP_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (clk_gate && st_reg == sdap_pkg::SDAP_ST_WRITE && !byte_mask),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (wr_word)
    );

    assign data_lines_o  = dout_reg;
    assign data_lines_oe = oe_reg;
    assign mode_word     = mode_reg;
    assign bank_open     = open_reg;
endmodule
`default_nettype wire

// ---- design/sdap_defs.svh ----
`ifndef SDAP_DEFS_SVH
`define SDAP_DEFS_SVH
`define SDAP_ROW_W        12
`define SDAP_COL_W        8
`define SDAP_DATA_W       16
`define SDAP_BANKS        4
`define SDAP_SCOPE_BIT    10
`define SDAP_MODE_RST     12'h000
`define SDAP_BL_LSB       0
`define SDAP_BT_BIT       3
`define SDAP_CL_LSB       4
`define SDAP_WBM_BIT      9
`define SDAP_MEM_DEPTH    64
`define SDAP_FIFO_DEPTH   4
`endif

// ---- design/sdap_pkg.sv ----
package sdap_pkg;
    typedef enum logic [3:0] {
        SDAP_CMD_INHIBIT  = 4'h0,
        SDAP_CMD_NOP      = 4'h1,
        SDAP_CMD_ACTIVE   = 4'h2,
        SDAP_CMD_READ     = 4'h3,
        SDAP_CMD_WRITE    = 4'h4,
        SDAP_CMD_PRECH    = 4'h5,
        SDAP_CMD_REFRESH  = 4'h6,
        SDAP_CMD_MODE     = 4'h7,
        SDAP_CMD_TERM     = 4'h8
    } sdap_cmd_t;
    typedef enum logic [1:0] {
        SDAP_ST_IDLE  = 2'b00,
        SDAP_ST_READ  = 2'b01,
        SDAP_ST_WRITE = 2'b10
    } sdap_state_t;
    typedef struct packed {
        logic        chip_sel_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  bank_select_lines;
        logic [11:0] multiplexed_address_lines;
    } sdap_cmd_bus_t;
    typedef struct packed {
        logic [1:0]  bank;
        logic [11:0] row;
        logic [7:0]  col;
        logic [15:0] data;
    } sdap_word_t;
endpackage

// ---- dv/sdap_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdap_chk (
    input wire logic                    clk_sys,       // Clock
    input wire logic                    rst_n,         // Reset
    input wire logic                    clk_gate,      // Gate
    input wire sdap_pkg::sdap_cmd_bus_t cmd_in,        // Command
    input wire logic                    data_lines_oe, // Drive
    input wire logic [11:0]             mode_word,     // Mode
    input wire logic [3:0]              bank_open      // Open rows
);
    wire logic [3:0]  fn   = {cmd_in.chip_sel_n, cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n};
    wire logic [1:0]  ba   = cmd_in.bank_select_lines;
    wire logic [11:0] am   = cmd_in.multiplexed_address_lines;
    wire logic        live = clk_gate && !fn[3];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_mode;
        live && fn == 4'h0;
    endsequence
    sequence s_prech(logic all);
        live && fn == 4'h2 && am[10] == all;
    endsequence
    a_mode_store: assert property (s_mode |=> mode_word == $past(am))
        else $error("mode not stored");
    a_mode_hold: assert property (!(live && fn == 4'h0) |=> $stable(mode_word))
        else $error("mode changed");
    a_oe_quiet: assert property (s_mode |-> ##2 !data_lines_oe)
        else $error("driving after mode load");
    a_act_open: assert property (live && fn == 4'h3 |=> bank_open[$past(ba)])
        else $error("row not opened");
    a_prech_all: assert property (s_prech(1'b1) |=> bank_open == 4'h0)
        else $error("banks not all closed");
    a_prech_one: assert property (s_prech(1'b0) |=> !bank_open[$past(ba)])
        else $error("bank not closed");
    a_cs_ignore: assert property (clk_gate && fn[3] && !bank_open[ba] |=> !bank_open[$past(ba)])
        else $error("deselected command taken");
    a_gate_hold: assert property (!clk_gate |=> $stable({mode_word, bank_open, data_lines_oe}))
        else $error("state moved while gated");
endmodule
`default_nettype wire

// ---- dv/sdap_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdap_ctrl_model #(
    parameter int          PWR_WAIT  = 12500,  // 100 us of 8 ns cycles
    parameter int          T_RP      = 3,
    parameter int          T_RFC     = 9,
    parameter int          T_MRD     = 2,
    parameter logic [11:0] MODE_INIT = 12'h002
) (
    input  wire logic                     clk_sys,  // Clock
    input  wire logic                     rst_n,    // Reset
    input  wire logic                     go,       // Issue request
    input  wire logic [3:0]               rq_cmd,   // Command code
    input  wire logic [1:0]               rq_bank,  // Bank
    input  wire logic [11:0]              rq_addr,  // Address
    output var  sdap_pkg::sdap_cmd_bus_t  cmd_out,  // To device
    output logic                          gate_out, // Clock gate
    output logic                          init_done // Traffic allowed
);
    // Deselect keeps strobes shaped like an active so a leak shows
    logic [3:0] fn_of [9] = '{4'hb, 4'h7, 4'h3, 4'h5, 4'h4, 4'h2, 4'h1, 4'h0, 4'h6};
    logic [3:0] seq_cmd [4] = '{4'h5, 4'h6, 4'h6, 4'h7};
    int         seq_wait [5] = '{PWR_WAIT, T_RP, T_RFC, T_RFC, T_MRD};
    int         cnt;
    int         step;
    function automatic sdap_pkg::sdap_cmd_bus_t enc(logic [3:0] c, logic [1:0] b, logic [11:0] a);
        return {fn_of[c], b, a};
    endfunction
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt = 0;
            step = 0;
            gate_out <= 1'b0;
            init_done <= 1'b0;
            cmd_out <= enc(4'h1, 2'h0, 12'h000);
        end
        else
        begin
            cnt = cnt + 1;
            if (cnt > PWR_WAIT / 2)
                gate_out <= 1'b1;
            if (step < 4 && cnt > seq_wait[step])
                cmd_out <= enc(seq_cmd[step], 2'h0, step == 0 ? 12'h400 : step == 3 ? MODE_INIT : 12'h000);
            else if (step == 5 && go)
                cmd_out <= enc(rq_cmd, rq_bank, rq_addr);
            else
                // Idle address lines toggle so nothing stale looks valid
                cmd_out <= enc(4'h1, ~cmd_out.bank_select_lines, ~cmd_out.multiplexed_address_lines);
            if (step < 5 && cnt > seq_wait[step])
            begin
                init_done <= (step == 4);
                step = step + 1;
                cnt = 0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [3:0]  c;
        logic [1:0]  b;
        logic [11:0] a;
        logic [3:0]  open;
        logic [11:0] mode;
    } sdap_row_t;
    sdap_row_t rows [11] = '{
        '{4'h2, 2'h0, 12'h005, 4'h1, 12'h002}, '{4'h2, 2'h2, 12'h005, 4'h5, 12'h002},
        '{4'h2, 2'h3, 12'h005, 4'hd, 12'h002}, '{4'h5, 2'h2, 12'h000, 4'h9, 12'h002},
        '{4'h5, 2'h1, 12'h400, 4'h0, 12'h002}, '{4'h6, 2'h0, 12'h000, 4'h0, 12'h002},
        '{4'h0, 2'h1, 12'h005, 4'h0, 12'h002}, '{4'h1, 2'h1, 12'h005, 4'h0, 12'h002},
        '{4'h7, 2'h0, 12'h033, 4'h0, 12'h033}, '{4'h7, 2'h0, 12'h002, 4'h0, 12'h002},
        '{4'h2, 2'h1, 12'h005, 4'h2, 12'h002}};
    logic                    clk_sys = 1'b0;
    logic                    rst_n, tb_gate, go, byte_mask, wr_ready, m_gate, init_done;
    logic                    data_lines_oe, wr_valid;
    logic [3:0]              rq_cmd, bank_open;
    logic [1:0]              rq_bank;
    logic [11:0]             rq_addr, mode_word;
    logic [15:0]             data_lines_i = 16'h0000, data_lines_o, wbase, wdat [4];
    sdap_pkg::sdap_cmd_bus_t cmd_in;
    sdap_pkg::sdap_word_t    wr_word;
    int                      miscompares = 0, n_checks = 0, cycles = 0, oe_cnt = 0, k;
    wire logic               clk_gate = m_gate & tb_gate;
    sdap_ctrl_model #(.PWR_WAIT(20), .T_RP(2), .T_RFC(3), .T_MRD(2)) u_ctrl (
        .clk_sys(clk_sys), .rst_n(rst_n), .go(go), .rq_cmd(rq_cmd), .rq_bank(rq_bank),
        .rq_addr(rq_addr), .cmd_out(cmd_in), .gate_out(m_gate), .init_done(init_done));
    sdap_core u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_gate(clk_gate), .cmd_in(cmd_in),
        .byte_mask(byte_mask), .data_lines_i(data_lines_i), .data_lines_o(data_lines_o),
        .data_lines_oe(data_lines_oe), .mode_word(mode_word), .bank_open(bank_open),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word));
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
        data_lines_i <= data_lines_i + 16'h0001;
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
        go <= 1'b1;
        rq_cmd <= c;
        rq_bank <= b;
        rq_addr <= a;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic wait_init();
        for (int i = 0; i < 60 && init_done !== 1'b1; i++)
            @(posedge clk_sys);
    endtask
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (data_lines_oe === 1'b1)
        begin
            // Only the first read burst has known data
            if (oe_cnt < 4)
                check(data_lines_o, wdat[oe_cnt[1:0]], "read data");
            oe_cnt <= oe_cnt + 1;
        end
        if (cycles == 2000)
        begin
            miscompares++;
            end_sim();
        end
    end
    initial
    begin
        rst_n = 1'b0;
        tb_gate = 1'b1;
        go = 1'b0;
        byte_mask = 1'b0;
        wr_ready = 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        wait_init();
        foreach (rows[i])
        begin
            issue(rows[i].c, rows[i].b, rows[i].a);
            check(bank_open, rows[i].open, "bank open");
            check(mode_word, rows[i].mode, "mode word");
        end
        // Sink stalls so the whole burst piles up in the FIFO
        issue(4'h4, 2'h1, 12'h401);
        // Data pins count up each cycle; the first beat took the previous count
        wbase = data_lines_i - 16'h0001;
        repeat (6) @(posedge clk_sys);
        check(wr_valid, 1'b1, "write held");
        check(bank_open, 4'h0, "auto precharge");
        wr_ready <= 1'b1;
        k = 0;
        repeat (8)
        begin
            @(posedge clk_sys);
            if (wr_valid === 1'b1 && k < 4)
            begin
                wdat[2'((k + 1) % 4)] = wbase + 16'(k);
                check(wr_word.col, 8'((k + 1) % 4), "burst col");
                check({wr_word.bank, wr_word.row}, 14'h1005, "bank row");
                check(wr_word.data, wbase + 16'(k), "burst data");
                k = k + 1;
            end
        end
        check(k, 4, "burst beats");
        check(wr_valid, 1'b0, "fifo drained");
        issue(4'h2, 2'h1, 12'h005);
        oe_cnt = 0;
        issue(4'h3, 2'h1, 12'h000);
        repeat (8) @(posedge clk_sys);
        check(oe_cnt, 4, "read beats");
        tb_gate <= 1'b0;
        issue(4'h2, 2'h3, 12'h005);
        check(bank_open, 4'h2, "gated active");
        tb_gate <= 1'b1;
        // Interleaved burst of eight against a stalled sink fills the FIFO
        wr_ready <= 1'b0;
        issue(4'h7, 2'h0, 12'h00b);
        issue(4'h2, 2'h0, 12'h007);
        issue(4'h4, 2'h0, 12'h005);
        repeat (4) @(posedge clk_sys);
        check(wr_valid, 1'b1, "stall held");
        wr_ready <= 1'b1;
        k = 0;
        repeat (16)
        begin
            @(posedge clk_sys);
            if (wr_valid === 1'b1)
            begin
                check(wr_word.col, 8'(5 ^ k), "interleave col");
                k = k + 1;
            end
        end
        check(k, 8, "interleave beats");
        // Burst terminate cuts a read of eight after four beats
        oe_cnt = 8;
        issue(4'h3, 2'h0, 12'h000);
        issue(4'h8, 2'h0, 12'h000);
        repeat (8) @(posedge clk_sys);
        check(oe_cnt, 12, "terminated beats");
        rst_n <= 1'b0;
        @(posedge clk_sys);
        check({mode_word, bank_open, wr_valid}, 17'h0, "reset state");
        @(posedge clk_sys);
        rst_n <= 1'b1;
        wait_init();
        check(mode_word, 12'h002, "mode after init");
        end_sim();
    end
endmodule
bind sdap_core sdap_chk u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_gate(clk_gate), .cmd_in(cmd_in),
    .data_lines_oe(data_lines_oe), .mode_word(mode_word), .bank_open(bank_open));
`default_nettype wire
